//--- design/mscr_pkg.sv
/*
 * constants for the memory subsystem configuration register slice:
 * byte offsets, writable masks, reset values, field positions and
 * the wait-state table of the nvm controllers.
 * assumes a 32-bit axi4-lite slave with a 12-bit byte address.
 */
package mscr_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int NREG = 9;
	localparam int AW = 12;
	localparam logic [3:0] IDX_NONE = 4'hf;
	localparam logic [AW-1:0] OFFS [0:NREG-1] = '{
		12'h00c, 12'h014, 12'h028, 12'h02c, 12'h030,
		12'h034, 12'h038, 12'h03c, 12'h040};
	localparam logic [3:0] R_NVM_CFG = 4'h0;
	localparam logic [3:0] R_REMAP = 4'h1;
	localparam logic [3:0] R_TIMEOUT = 4'h2;
	localparam logic [3:0] R_NB_BASE = 4'h3;
	localparam logic [3:0] R_NB_SIZE = 4'h4;
	localparam logic [3:0] R_DDR_CFG = 4'h5;
	localparam logic [3:0] R_ECC = 4'h6;
	localparam logic [3:0] R_WEIGHT0 = 4'h7;
	localparam logic [3:0] R_WEIGHT1 = 4'h8;
	// writable bits; everything else is reserved and reads zero
	localparam logic [31:0] WMASK [0:NREG-1] = '{
		32'h0001_ffff, 32'h0007_ffff, 32'h0000_03ff, 32'h0000_ffff,
		32'h0000_000f, 32'h000f_f0bc, 32'h0000_0003, 32'h3fff_8000,
		32'h0000_7c1f};
	localparam logic [31:0] RSTVAL [0:NREG-1] = '{
		32'h0000_00f1, 32'h0000_0000, 32'h0000_03ff, 32'h0000_a000,
		32'h0000_0001, 32'h0000_00bc, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0000};

	// ****************************************
	// field positions
	// ****************************************
	localparam int B_SENSE = 16;
	localparam int B_PERSIST = 15;
	localparam int B_DPD1 = 14;
	localparam int B_DPD0 = 13;
	localparam int F_WAIT0_LO = 5;
	localparam int F_WAIT1_LO = 9;
	localparam int F_RSIZE_LO = 0;
	localparam int B_REMAP_EN = 0;
	localparam int B_BUF_SZ = 7;
	localparam int B_BUS_REN = 5;
	localparam int B_BUS_WEN = 4;
	localparam int B_DMA_REN = 3;
	localparam int B_DMA_WEN = 2;
	localparam int F_BUS_MAP_LO = 16;
	localparam int F_DMA_MAP_LO = 12;
	localparam int B_SRAM1_ECC = 1;
	localparam int B_SRAM0_ECC = 0;
	localparam int F_W_PERIPH_DMA_MASTER = 25;
	localparam int F_W_FAB1 = 20;
	localparam int F_W_FAB0 = 15;
	localparam int F_W_G = 10;
	localparam int F_W_FAST = 0;

	// ****************************************
	// decode constants
	// ****************************************
	localparam logic [3:0] WAIT_MIN_CODE = 4'h2;
	localparam logic [4:0] RSIZE_MIN = 5'h0d; // 16 kbyte segment
	localparam logic [4:0] RSIZE_MAX = 5'h12; // 512 kbyte segment
	localparam logic [4:0] RSIZE_TO_LOG2 = 5'h01; // log2 = code + 1
	localparam logic [5:0] WEIGHT_ZERO = 6'h20;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam logic [4:0] BUF_BYTES_SMALL = 5'h10;
	localparam logic [5:0] BUF_BYTES_LARGE = 6'h20;
	// program and verify wait counts, indexed by code
	localparam logic [4:0] PROG_WAIT [0:15] = '{
		5'h02, 5'h02, 5'h02, 5'h02, 5'h02, 5'h03, 5'h03, 5'h04,
		5'h04, 5'h04, 5'h05, 5'h05, 5'h06, 5'h06, 5'h06, 5'h07};

endpackage

//--- design/mscr_regs.sv
/*
 * memory subsystem configuration registers behind an axi4-lite slave,
 * with the logic they steer: nvm wait sequencers, nvm reset gating,
 * remap base alignment, non-bufferable region match, write-buffer
 * flush controller and arbitration weight decode.
 * assumes one clock (aclk); reset pins arrive asynchronously.
 */
// Functional notes
// - sense amp bit drives both nvm arrays
// - persist bit limits nvm reset to power-on
// - deep power-down bits per nvm array
// - wait range nibbles, low array0, reset 0x7 array0, 0x0 array1
// - read wait is code plus one; 0,1 unsupported
// - program/verify waits follow fixed table
// - counter loaded from range sets busy, capture
// - remap size codes 16 kbyte to 512 kbyte
// - remap enable selects segment at zero
// - remap base aligned to segment size
// - flush timeout ten bits, reset 0x3ff
// - flush posted only after previous response
// - non-bufferable base compared with upper address
// - region size code 0 none, 64 kbyte doubling
// - two four-bit ddr map modes, reset zero
// - buffer size bit, 16 or 32 bytes
// - four buffer enable bits, reset one
// - two sram correction enables, reset zero
// - five weight fields at fixed positions
// - weight zero means thirty-two
`timescale 1ns/100ps
module mscr_regs (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// reset pins, asynchronous
	input wire logic system_reset_n,
	input wire logic power_on_reset_n,
	// nvm controls
	output logic nvm_sense_amp_on,
	output logic nvm_ctrl_reset_n,
	output logic nvm1_deep_powerdown,
	output logic nvm0_deep_powerdown,
	output logic [4:0] nvm_remap_segment_size,
	output logic fabric_remap_enable,
	output logic [18:0] fabric_remap_base,
	// nvm access sequencers, index = array
	input wire logic [1:0] nvm_access_start,
	input wire logic [1:0] nvm_access_program,
	output logic [1:0] nvm_busy,
	output logic [1:0] nvm_capture,
	// ddr bridge write buffer flush
	input wire logic wbuf_pending,
	input wire logic wr_req_sent,
	input wire logic wr_resp_recv,
	output logic flush_raised,
	output logic flush_post,
	// ddr bridge non-bufferable match
	input wire logic [31:0] ahb_addr,
	output logic nonbuffer_hit,
	// ddr bridge settings
	output logic [3:0] bus_master_map_mode,
	output logic [3:0] dma_master_map_mode,
	output logic [5:0] bridge_buffer_bytes,
	output logic bus_read_buffer_enable,
	output logic bus_write_combine_enable,
	output logic dma_read_buffer_enable,
	output logic dma_write_combine_enable,
	// sram correction and arbitration
	output logic sram1_correction_enable,
	output logic sram0_correction_enable,
	output logic [5:0] periph_dma_weight,
	output logic [5:0] fabric_port1_weight,
	output logic [5:0] fabric_port0_weight,
	output logic [5:0] master_g_weight,
	output logic [5:0] fast_dma_weight
);

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [3:0] addr_index(input logic [11:0] a);
		logic [3:0] idx;
		idx = mscr_pkg::IDX_NONE;
		for (int i = 0; i < mscr_pkg::NREG; i++) begin
			if (a == mscr_pkg::OFFS[i])
				idx = 4'(i);
		end
		return idx;
	endfunction

	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// wait count for one access; unsupported codes act as lowest code
	function automatic logic [4:0] nvm_wait(input logic [3:0] code,
			input logic prog);
		logic [3:0] c;
		c = (code < mscr_pkg::WAIT_MIN_CODE) ?
			mscr_pkg::WAIT_MIN_CODE : code;
		if (prog)
			return mscr_pkg::PROG_WAIT[c];
		return 5'(c) + 5'h01;
	endfunction

	function automatic logic [5:0] weight_of(input logic [4:0] f);
		return (f == 5'h00) ? mscr_pkg::WEIGHT_ZERO : {1'b0, f};
	endfunction

	// ****************************************
	// register file and axi4-lite slave
	// ****************************************
	logic [31:0] regs [0:mscr_pkg::NREG-1];
	logic aw_held, w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire logic commit = aw_held & w_held & ~s_axi_bvalid;
	wire logic [3:0] wr_idx = addr_index(aw_addr);
	wire logic [3:0] rd_idx = addr_index(s_axi_araddr);
	wire logic [31:0] wr_lanes = lane_mask(w_strb);
	wire logic ar_take = s_axi_arvalid & s_axi_arready;

	assign s_axi_awready = ~aw_held;
	assign s_axi_wready = ~w_held;
	assign s_axi_arready = ~s_axi_rvalid;

	// address and data may come in either order; held until both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (commit)
				aw_held <= 1'b0;
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (commit)
				w_held <= 1'b0;
		end
	end

	// byte lanes merge per strobe; remap base expects whole words
	always_ff @(posedge aclk) begin
		for (int i = 0; i < mscr_pkg::NREG; i++) begin
			if (!aresetn)
				regs[i] <= mscr_pkg::RSTVAL[i];
			else if (commit && wr_idx == 4'(i))
				regs[i] <= ((regs[i] & ~wr_lanes) | (w_data & wr_lanes))
					& mscr_pkg::WMASK[i];
		end
	end

	// write response; unmapped offsets answer decode error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= mscr_pkg::RESP_OKAY;
		end else if (commit) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_idx == mscr_pkg::IDX_NONE) ?
				mscr_pkg::RESP_DECERR : mscr_pkg::RESP_OKAY;
		end else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= mscr_pkg::RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			if (rd_idx == mscr_pkg::IDX_NONE) begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= mscr_pkg::RESP_DECERR;
			end else begin
				s_axi_rdata <= regs[rd_idx[3:0]];
				s_axi_rresp <= mscr_pkg::RESP_OKAY;
			end
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ****************************************
	// field decode
	// ****************************************
	wire logic [31:0] nvm_cfg = regs[mscr_pkg::R_NVM_CFG];
	wire logic [31:0] ddr_cfg = regs[mscr_pkg::R_DDR_CFG];
	wire logic [31:0] wt0 = regs[mscr_pkg::R_WEIGHT0];
	wire logic [31:0] wt1 = regs[mscr_pkg::R_WEIGHT1];
	wire logic [1:0][3:0] wait_code = {
		nvm_cfg[mscr_pkg::F_WAIT1_LO +: 4],
		nvm_cfg[mscr_pkg::F_WAIT0_LO +: 4]};
	wire logic [1:0] dpd = {nvm_cfg[mscr_pkg::B_DPD1],
		nvm_cfg[mscr_pkg::B_DPD0]};

	assign nvm_sense_amp_on = nvm_cfg[mscr_pkg::B_SENSE];
	assign nvm1_deep_powerdown = dpd[1];
	assign nvm0_deep_powerdown = dpd[0];
	assign nvm_remap_segment_size = nvm_cfg[mscr_pkg::F_RSIZE_LO +: 5];
	assign bus_master_map_mode = ddr_cfg[mscr_pkg::F_BUS_MAP_LO +: 4];
	assign dma_master_map_mode = ddr_cfg[mscr_pkg::F_DMA_MAP_LO +: 4];
	assign bridge_buffer_bytes = ddr_cfg[mscr_pkg::B_BUF_SZ] ?
		mscr_pkg::BUF_BYTES_LARGE :
		{1'b0, mscr_pkg::BUF_BYTES_SMALL};
	assign bus_read_buffer_enable = ddr_cfg[mscr_pkg::B_BUS_REN];
	assign bus_write_combine_enable = ddr_cfg[mscr_pkg::B_BUS_WEN];
	assign dma_read_buffer_enable = ddr_cfg[mscr_pkg::B_DMA_REN];
	assign dma_write_combine_enable = ddr_cfg[mscr_pkg::B_DMA_WEN];
	assign sram1_correction_enable =
		regs[mscr_pkg::R_ECC][mscr_pkg::B_SRAM1_ECC];
	assign sram0_correction_enable =
		regs[mscr_pkg::R_ECC][mscr_pkg::B_SRAM0_ECC];
	// weights decoded to 1..32 so the arbiter sees true counts
	assign periph_dma_weight = weight_of(wt0[mscr_pkg::F_W_PERIPH_DMA_MASTER +: 5]);
	assign fabric_port1_weight = weight_of(wt0[mscr_pkg::F_W_FAB1 +: 5]);
	assign fabric_port0_weight = weight_of(wt0[mscr_pkg::F_W_FAB0 +: 5]);
	assign master_g_weight = weight_of(wt1[mscr_pkg::F_W_G +: 5]);
	assign fast_dma_weight = weight_of(wt1[mscr_pkg::F_W_FAST +: 5]);

	// ****************************************
	// remap base alignment
	// ****************************************
	// reserved size codes clamp into the table so the mask stays sane
	wire logic [4:0] rsize_c =
		(nvm_remap_segment_size < mscr_pkg::RSIZE_MIN) ? mscr_pkg::RSIZE_MIN :
		(nvm_remap_segment_size > mscr_pkg::RSIZE_MAX) ? mscr_pkg::RSIZE_MAX :
		nvm_remap_segment_size;
	wire logic [4:0] remap_log2 = rsize_c + mscr_pkg::RSIZE_TO_LOG2;
	wire logic [18:0] remap_keep = 19'h7_ffff << remap_log2;
	assign fabric_remap_enable =
		regs[mscr_pkg::R_REMAP][mscr_pkg::B_REMAP_EN];
	// offset is zero when disabled: bottom of nvm sits at address zero
	assign fabric_remap_base = fabric_remap_enable ?
		(regs[mscr_pkg::R_REMAP][18:0] & remap_keep) : 19'h0_0000;

	// ****************************************
	// nvm reset gating
	// ****************************************
	logic [2:0] sys_sync, por_sync;
	logic sys_f, por_f;

	// third stage agrees with second before a change counts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_sync <= 3'h0;
			por_sync <= 3'h0;
			sys_f <= 1'b0;
			por_f <= 1'b0;
			nvm_ctrl_reset_n <= 1'b0;
		end else begin
			sys_sync <= {sys_sync[1:0], system_reset_n};
			por_sync <= {por_sync[1:0], power_on_reset_n};
			if (sys_sync[1] == sys_sync[2])
				sys_f <= sys_sync[2];
			if (por_sync[1] == por_sync[2])
				por_f <= por_sync[2];
			nvm_ctrl_reset_n <= por_f &
				(sys_f | nvm_cfg[mscr_pkg::B_PERSIST]);
		end
	end

	// ****************************************
	// nvm wait-state sequencers
	// ****************************************
	logic [4:0] wait_cnt [0:1];
	logic [1:0] seq_prog;
	// access refused while sense amps off or array powered down
	wire logic [1:0] seq_go = nvm_access_start & ~nvm_busy & ~dpd
		& {2{nvm_sense_amp_on}};

	always_ff @(posedge aclk) begin
		for (int k = 0; k < 2; k++) begin
			if (!aresetn) begin
				wait_cnt[k] <= 5'h00;
				nvm_busy[k] <= 1'b0;
				nvm_capture[k] <= 1'b0;
				seq_prog[k] <= 1'b0;
			end else if (seq_go[k]) begin
				wait_cnt[k] <= nvm_wait(wait_code[k],
					nvm_access_program[k]);
				nvm_busy[k] <= 1'b1;
				nvm_capture[k] <= 1'b0;
				seq_prog[k] <= nvm_access_program[k];
			end else if (nvm_busy[k]) begin
				wait_cnt[k] <= wait_cnt[k] - 5'h01;
				nvm_busy[k] <= (wait_cnt[k] != 5'h01);
				nvm_capture[k] <= (wait_cnt[k] == 5'h01);
			end else
				nvm_capture[k] <= 1'b0;
		end
	end

	// ****************************************
	// write buffer flush controller
	// ****************************************
	typedef enum logic [1:0] {
		FL_COUNT = 2'b01,
		FL_RAISED = 2'b10
	} mscr_flush_t;
	mscr_flush_t fl_state, next_fl_state;
	logic [9:0] fl_timer;
	logic outstanding;
	wire logic [9:0] fl_limit = regs[mscr_pkg::R_TIMEOUT][9:0];
	wire logic fl_fire = (fl_state == FL_RAISED) & ~outstanding;

	always_comb begin
		next_fl_state = fl_state;
		case (fl_state)
			FL_COUNT:
				if (wbuf_pending && fl_timer >= fl_limit)
					next_fl_state = FL_RAISED;
			FL_RAISED:
				if (fl_fire)
					next_fl_state = FL_COUNT;
			default:
				next_fl_state = FL_COUNT;
		endcase
	end

	// timer counts clocks while data waits in a buffer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fl_state <= FL_COUNT;
			fl_timer <= 10'h000;
			flush_post <= 1'b0;
		end else begin
			fl_state <= next_fl_state;
			flush_post <= fl_fire;
			if (!wbuf_pending || fl_state != FL_COUNT)
				fl_timer <= 10'h000;
			else if (fl_timer < fl_limit)
				fl_timer <= fl_timer + 10'h001;
		end
	end
	assign flush_raised = (fl_state == FL_RAISED);

	// a new request in the response cycle keeps the flag set
	always_ff @(posedge aclk) begin
		if (!aresetn)
			outstanding <= 1'b0;
		else if (wr_req_sent || fl_fire)
			outstanding <= 1'b1;
		else if (wr_resp_recv)
			outstanding <= 1'b0;
	end

	// ****************************************
	// non-bufferable region match
	// ****************************************
	wire logic [3:0] nb_size = regs[mscr_pkg::R_NB_SIZE][3:0];
	wire logic [16:0] nb_keep = 17'h1_ffff << nb_size;
	wire logic [16:0] nb_diff = ahb_addr[31:15] ^
		{regs[mscr_pkg::R_NB_BASE][15:0], 1'b0};
	wire logic nb_match = (nb_size != 4'h0) &&
		((nb_diff & nb_keep) == 17'h0_0000);

	// registered so the bridge samples a clean flag
	always_ff @(posedge aclk) begin
		if (!aresetn)
			nonbuffer_hit <= 1'b0;
		else
			nonbuffer_hit <= nb_match;
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_sense_write: assert property (
		commit && wr_idx == mscr_pkg::R_NVM_CFG && w_strb == 4'hf
		|=> nvm_sense_amp_on == $past(w_data[mscr_pkg::B_SENSE]))
		else $error("sense amp output missed a write");
	a_persist_reset: assert property (
		!por_f |=> !nvm_ctrl_reset_n)
		else $error("nvm reset not held by power-on reset");
	a_dpd_refuse: assert property (
		dpd[0] && !nvm_busy[0] |=> !nvm_busy[0])
		else $error("powered-down array started an access");
	a_read_wait: assert property (
		$rose(nvm_busy[0]) && !seq_prog[0] |-> nvm_busy[0][*3])
		else $error("read wait shorter than three cycles");
	a_capture_end: assert property (
		nvm_capture[0] |-> $past(nvm_busy[0]) && !nvm_busy[0])
		else $error("capture not at end of busy");
	a_weight_zero: assert property (
		wt1[4:0] == 5'h00 |-> fast_dma_weight == 6'h20)
		else $error("zero weight not decoded as 32");
	a_flush_after: assert property (
		flush_post |-> $past(flush_raised) && !$past(outstanding))
		else $error("flush posted with write outstanding");
	a_nb_none: assert property (
		nb_size == 4'h0 |=> !nonbuffer_hit)
		else $error("hit with no region configured");
	a_remap_align: assert property (
		rsize_c == 5'h0f |-> fabric_remap_base[15:0] == 16'h0000)
		else $error("remap base not segment aligned");
	a_reserved_zero: assert property (
		ar_take && rd_idx == mscr_pkg::R_ECC
		|=> s_axi_rdata[31:2] == 30'h0000_0000)
		else $error("reserved bits read nonzero");

	c_flush: cover property (flush_post);
	c_capture: cover property (nvm_capture[1]);
	c_nb_hit: cover property (nonbuffer_hit);
	c_write_done: cover property (s_axi_bvalid && s_axi_bready);

endmodule

//--- testbench/tb_mscr_regs.sv
/*
 * self-checking bench for the memory subsystem configuration registers.
 * assumes the axi4-lite slave of mscr_regs and the offsets of mscr_pkg.
 */
`timescale 1ns/100ps
module tb_mscr_regs;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, system_reset_n;
	logic power_on_reset_n, nvm_sense_amp_on, nvm_ctrl_reset_n;
	logic nvm1_deep_powerdown, nvm0_deep_powerdown, fabric_remap_enable;
	logic wbuf_pending, wr_req_sent, wr_resp_recv, flush_raised, flush_post;
	logic nonbuffer_hit, bus_read_buffer_enable, bus_write_combine_enable;
	logic dma_read_buffer_enable, dma_write_combine_enable;
	logic sram1_correction_enable, sram0_correction_enable;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, ahb_addr;
	logic [3:0] s_axi_wstrb, bus_master_map_mode, dma_master_map_mode;
	logic [1:0] s_axi_bresp, s_axi_rresp, nvm_access_start;
	logic [1:0] nvm_access_program, nvm_busy, nvm_capture;
	logic [4:0] nvm_remap_segment_size;
	logic [18:0] fabric_remap_base;
	logic [5:0] bridge_buffer_bytes, periph_dma_weight, fabric_port1_weight;
	logic [5:0] fabric_port0_weight, master_g_weight, fast_dma_weight;
	logic [31:0] d, v, a, m [0:8];
	logic [15:0] b;
	logic [1:0] rs;
	logic bad;
	int errors, n_checks, n;
	// expected reset values and writable masks, register order of the map
	logic [31:0] RST [0:8] = '{32'hf1, 0, 32'h3ff, 32'ha000, 1, 32'hbc, 0, 0, 0};
	logic [31:0] MSK [0:8] = '{32'h1ffff, 32'h7ffff, 32'h3ff, 32'hffff,
		32'hf, 32'hff0bc, 32'h3, 32'h3fff8000, 32'h7c1f};
	int PT [0:15] = '{2, 2, 2, 2, 2, 3, 3, 4, 4, 4, 5, 5, 6, 6, 6, 7};

	mscr_regs dut (.*);

	initial begin
		aclk = 0;
		forever #2 aclk = ~aclk;
	end

	// ****************************************
	// bus cycles and comparisons
	// ****************************************
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask

	// address and data offered together, each released when taken
	task automatic wr(logic [11:0] ad, logic [31:0] dt);
		s_axi_awaddr <= ad;
		s_axi_wdata <= dt;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
		end while (!(s_axi_bvalid === 1'b1));
		rs = s_axi_bresp;
	endtask

	task automatic rd(logic [11:0] ad);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
		end while (!(s_axi_rvalid === 1'b1));
		d = s_axi_rdata;
		rs = s_axi_rresp;
	endtask

	function automatic logic [5:0] wt(logic [4:0] f);
		return f == 0 ? 6'h20 : {1'b0, f};
	endfunction

	// reserved size codes are clamped, so alignment is 14 to 19 bits
	function automatic logic [18:0] rb(logic [31:0] r, logic [4:0] c);
		int l;
		l = c < 13 ? 14 : c > 18 ? 19 : c + 1;
		return r[0] ? r[18:0] & ~((19'h1 << l) - 1) : 19'h0;
	endfunction

	function automatic logic nbx(logic [31:0] x, logic [15:0] y, int s);
		return s != 0 && (x >> (15 + s)) == (32'(y) >> (s - 1));
	endfunction

	task automatic chk_outs();
		chk("nvm", 32'({m[0][16], m[0][14:13], m[0][4:0]}),
			32'({nvm_sense_amp_on, nvm1_deep_powerdown,
			nvm0_deep_powerdown, nvm_remap_segment_size}));
		chk("remap", 32'({m[1][0], rb(m[1], m[0][4:0])}),
			32'({fabric_remap_enable, fabric_remap_base}));
		chk("ddr", 32'({m[5][19:12], m[5][5:2], m[6][1:0]}),
			32'({bus_master_map_mode, dma_master_map_mode,
			bus_read_buffer_enable, bus_write_combine_enable,
			dma_read_buffer_enable, dma_write_combine_enable,
			sram1_correction_enable, sram0_correction_enable}));
		chk("bytes", m[5][7] ? 32 : 16, 32'(bridge_buffer_bytes));
		chk("weights", {2'b0, wt(m[7][29:25]), wt(m[7][24:20]),
			wt(m[7][19:15]), wt(m[8][14:10]), wt(m[8][4:0])},
			{2'b0, periph_dma_weight, fabric_port1_weight,
			fabric_port0_weight, master_g_weight, fast_dma_weight});
	endtask

	task automatic chk_rst();
		for (int i = 0; i < 9; i++) begin
			rd(mscr_pkg::OFFS[i]);
			chk("reset value", RST[i], d);
			m[i] = RST[i];
		end
		chk_outs();
	endtask

	// count busy cycles of one array access
	task automatic seq(int k, int p, int w);
		int c;
		@(posedge aclk);
		nvm_access_start <= 2'(1 << k);
		nvm_access_program <= 2'(p << k);
		@(posedge aclk);
		nvm_access_start <= 0;
		c = 0;
		@(negedge aclk);
		while (nvm_busy[k] === 1'b1 && c < 40) begin
			c++;
			@(negedge aclk);
		end
		chk("busy cycles", w, c);
		chk("capture", 1, 32'(nvm_capture[k]));
	endtask

	task automatic st(logic [1:0] s, logic [1:0] e);
		@(posedge aclk);
		nvm_access_start <= s;
		@(posedge aclk);
		nvm_access_start <= 0;
		@(negedge aclk);
		chk("start refusal", 32'(e), 32'(nvm_busy));
		repeat (20) @(posedge aclk);
	endtask

	// pulse one reset pin and watch the nvm controller reset
	task automatic rp(logic [31:0] c, logic por, logic e);
		wr(12'h00c, c);
		bad = 0;
		if (por) power_on_reset_n <= 0;
		else system_reset_n <= 0;
		for (int j = 0; j < 16; j++) begin
			@(posedge aclk);
			if (j == 8) {system_reset_n, power_on_reset_n} <= 2'b11;
			@(negedge aclk);
			if (nvm_ctrl_reset_n !== 1'b1) bad = 1;
		end
		chk("nvm reset", 32'(e), 32'(bad));
		repeat (12) @(posedge aclk);
	endtask

	task automatic test_done();
		if (errors == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		aresetn = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, wbuf_pending, wr_req_sent, wr_resp_recv} = '0;
		{system_reset_n, power_on_reset_n} = 2'b11;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
		{s_axi_wdata, ahb_addr, nvm_access_start, nvm_access_program} = '0;
		s_axi_wstrb = 4'hf;
		void'($urandom(43706));
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk_rst();
		// all-zero, all-one, then random images
		for (int p = 0; p < 4; p++) begin
			for (int i = 0; i < 9; i++) begin
				v = p == 0 ? 32'h0 : p == 1 ? 32'hffffffff : $urandom;
				m[i] = v & MSK[i];
				wr(mscr_pkg::OFFS[i], v);
				chk("bresp", 0, 32'(rs));
				rd(mscr_pkg::OFFS[i]);
				chk("readback", m[i], d);
			end
			chk_outs();
		end
		wr(12'h044, 32'h1);
		chk("unmapped bresp", 3, 32'(rs));
		rd(12'h010);
		chk("unmapped read", 32'h3, d | 32'(rs));
		// codes 2 to 15 on both arrays; the other nibble holds another code
		for (int c = 2; c < 16; c++) begin
			for (int q = 0; q < 4; q++) begin
				v = 32'h10000 | 32'(c) << 5 | 32'(17 - c) << 9;
				if (q[1])
					v[12:5] = {v[8:5], v[12:9]};
				wr(12'h00c, v);
				seq(q[1], q[0], q[0] ? PT[c] : c + 1);
			end
		end
		wr(12'h00c, 32'h12000 | 32'h2 << 5 | 32'h2 << 9);
		st(2'b11, 2'b10);
		wr(12'h00c, 32'h44);
		st(2'b11, 2'b00);
		// flush with a write still outstanding
		wr(12'h028, 32'h4);
		wr_req_sent <= 1;
		@(posedge aclk);
		wr_req_sent <= 0;
		wbuf_pending <= 1;
		n = 0;
		@(negedge aclk);
		while (flush_raised !== 1'b1 && n < 20) begin
			n++;
			@(negedge aclk);
		end
		// four pending cycles reach the timeout, one more edge raises
		chk("raise delay", 5, n);
		bad = 0;
		repeat (6) begin
			@(negedge aclk);
			if (flush_post !== 1'b0) bad = 1;
		end
		chk("post held", 0, 32'(bad));
		@(posedge aclk);
		wr_resp_recv <= 1;
		@(posedge aclk);
		wr_resp_recv <= 0;
		n = 0;
		@(negedge aclk);
		while (flush_post !== 1'b1 && n < 4) begin
			n++;
			@(negedge aclk);
		end
		chk("post", 1, 32'(flush_post));
		@(posedge aclk);
		wbuf_pending <= 0;
		// non-bufferable region, matching address half the time
		repeat (24) begin
			n = $urandom % 16;
			b = 16'($urandom);
			wr(12'h030, 32'(n));
			wr(12'h02c, 32'(b));
			a = $urandom;
			if (a[0] && n > 0)
				a = ((32'(b) >> (n - 1)) << (15 + n)) |
					(a & ((32'h1 << (15 + n)) - 1));
			@(posedge aclk);
			ahb_addr <= a;
			@(posedge aclk);
			@(negedge aclk);
			chk("nb hit", 32'(nbx(a, b, n)), 32'(nonbuffer_hit));
		end
		rp(32'h0, 0, 1);
		rp(32'h8000, 0, 0);
		rp(32'h8000, 1, 1);
		// second device reset in mid-run
		@(posedge aclk);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk_rst();
		test_done();
	end

	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		test_done();
	end
endmodule
